// >>> esb_map.svh
// constants of the external sram bus cycle generator
`ifndef ESB_MAP_SVH
`define ESB_MAP_SVH
// system clock rate in hertz
`define ESB_CLK_HZ 10000000
// system clock ticks that make one bus state
`define ESB_TICKS_PER_STATE 20
// read strobe high share of the first bus state, percent
`define ESB_DUTY_SHORT_PCT 35
`define ESB_DUTY_HALF_PCT 50
// boot mode codes that leave area 0 as external memory
`define ESB_BOOT_EXT8 3'h0
`define ESB_BOOT_EXT16 3'h1
// bit of the first wait control register that picks store pitch
`define ESB_WCR_PITCH_BIT 1
// wait control registers: reset value, all wait enables set
`define ESB_WCR_RESET 8'hFF
// area whose wait pin is taken by the area 7 chip select
`define ESB_AREA_NOPIN 3'h3
// address bit that picks bus width in area 6
`define ESB_MUXIO_WIDTH_BIT 14
// address bits that select the area, and the top space bit
`define ESB_AREA_LSB 24
`define ESB_TOP_BIT 27
// chip select reset value, all inactive
`define ESB_CS_IDLE 8'hFF
`endif

// >>> esb_pkg.sv
// types of the external sram bus cycle generator
package esb_pkg;
    // bus cycle sequencer states
    typedef enum logic [2:0] {
        ESB_ST_IDLE,
        ESB_ST_FIRST,
        ESB_ST_LONG,
        ESB_ST_PINWAIT,
        ESB_ST_FINAL
    } esb_state_t;
    // who owns the bus cycle
    typedef enum logic [1:0] {
        ESB_KIND_CPU,
        ESB_KIND_DMA_DUAL,
        ESB_KIND_DMA_SINGLE,
        ESB_KIND_RSVD
    } esb_kind_t;
    // area number
    typedef logic [2:0] esb_area_t;
endpackage : esb_pkg

// >>> esb_state_timer.sv
// tick counter that divides each bus state into clock ticks
`timescale 1ns/100ps
module esb_state_timer #(
    parameter int TPS = 20,
    parameter int TW = 5
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // count while a bus cycle runs
    input wire logic i_run,
    // tick inside the current state and its last tick
    output logic [TW-1:0] o_tick,
    output logic o_last
);
    logic [TW-1:0] cnt_q;
    logic [TW-1:0] cnt_d;

    // wrap at the end of every state, hold zero when idle
    assign o_last = i_run & (cnt_q == TW'(TPS - 1));
    assign cnt_d = (!i_run || o_last) ? '0 : cnt_q + TW'(1);
    assign o_tick = cnt_q;

    // tick register
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule : esb_state_timer

// >>> esb_sram_cycle.sv
// external sram bus cycle generator: area decode, wait states, strobes
// What this block does
// - accept area 0,1,2-4,5,6,7 as sram space only under their mode conditions
// - run each external access as a base cycle of one or two states
// - read strobe stays high 35 percent of first state if duty bit set, else 50
// - processor and dual dma reads use wait reg one, single dma uses reg two
// - areas 1,3,4,5,7 with wait bit clear end in one state, pin ignored
// - same areas with wait bit set sample pin, two states plus pin waits
// - those areas sample wait low before second state, hold while low
// - areas 0,2,6 wait bit clear take one plus long waits, pin ignored
// - same areas wait bit set add pin waits to one plus long waits
// - long wait areas sample pin before last long wait, hold while low
// - processor writes in areas 1,3,4,5,7 always two states plus pin waits
// - processor writes in areas 0,2,6 take one plus long plus pin waits
// - with dram space on, the pitch bit picks short or long store pitch
// - area 3 never gets pin waits since its pin is shared
// - style bit set gives common store plus byte selects, clear gives split stores
// - pins share address bit/upper select, upper store/lower select, lower/common
// - both strobe styles work for byte access to sixteen bit spaces
// - eight bit spaces use address bit, common store, leave middle pin idle
// - areas 2 to 4 are eight bit at top bit 0, sixteen at 1, own select
// - area 6 long wait from its own field, areas 0 and 2 share another
`timescale 1ns/100ps
`include "esb_map.svh"
module esb_sram_cycle import esb_pkg::*; #(
    parameter int TPS = `ESB_TICKS_PER_STATE
) (
    // clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    // mode and configuration bits
    input wire logic [2:0] i_boot_mode_pins,
    input wire logic i_dram_space_enable,
    input wire logic i_mux_io_space_enable,
    input wire logic i_read_strobe_duty_select,
    input wire logic i_byte_strobe_style,
    input wire logic [7:0] i_wait_ctrl_reg_first,
    input wire logic [7:0] i_wait_ctrl_reg_second,
    input wire logic [1:0] i_long_wait_count_areas_0_2,
    input wire logic [1:0] i_long_wait_count_area_6,
    // access request
    input wire logic i_req,
    input wire logic [27:0] i_addr,
    input wire logic i_write,
    input wire logic i_word,
    input wire esb_kind_t i_kind,
    input wire logic [15:0] i_wdata,
    // access answer
    output logic o_busy,
    output logic o_done,
    output logic o_reject,
    output logic [15:0] o_rdata,
    // external memory pins
    input wire logic I_WAIT_N,
    input wire logic [15:0] i_data_in,
    output logic [15:0] o_data_out,
    output logic o_data_oe,
    output logic [21:0] o_addr,
    output logic [7:0] o_cs_n,
    output logic o_rd_n,
    output logic o_pin_a0_upsel_n,
    output logic o_pin_upst_losel_n,
    output logic o_pin_lost_st_n,
    output logic o_store_pitch_long
);
    localparam int TW = $clog2(TPS + 1);
    // high part of the first state in ticks, rounded up
    localparam int HI_SHORT = (TPS * `ESB_DUTY_SHORT_PCT + 99) / 100;
    localparam int HI_HALF = (TPS * `ESB_DUTY_HALF_PCT + 99) / 100;

    // captured access, steady for the whole cycle
    esb_state_t st_q;
    esb_state_t st_d;
    logic [1:0] left_q;
    logic [1:0] left_d;
    logic [27:0] addr_q;
    esb_area_t area_q;
    logic write_q;
    logic word_q;
    logic wide_q;
    logic longw_q;
    logic use_wait_q;
    logic pin_ok_q;
    logic [1:0] lw_q;
    logic duty_q;
    logic style_q;
    logic [15:0] wdata_q;
    logic done_q;
    logic reject_q;
    logic [15:0] rdata_q;

    // timer outputs
    logic [TW-1:0] tick;
    logic st_last;
    logic running;

    // request decode
    esb_area_t req_area;
    logic req_top;
    logic [7:0] area_ext;
    logic req_ext;
    logic take;
    logic req_longw;
    logic [7:0] wait_bits;
    logic req_use_wait;
    logic req_pin_ok;
    logic req_wide;
    logic [1:0] req_lw;
    logic finish;

    assign req_area = i_addr[`ESB_AREA_LSB+2:`ESB_AREA_LSB];
    assign req_top = i_addr[`ESB_TOP_BIT];

    // which areas are plain external memory right now
    assign area_ext[0] = (i_boot_mode_pins == `ESB_BOOT_EXT8) | (i_boot_mode_pins == `ESB_BOOT_EXT16);
    assign area_ext[1] = ~i_dram_space_enable;
    assign area_ext[2] = 1'b1;
    assign area_ext[3] = 1'b1;
    assign area_ext[4] = 1'b1;
    assign area_ext[5] = req_top;
    assign area_ext[6] = ~i_mux_io_space_enable | req_top;
    assign area_ext[7] = ~req_top;
    assign req_ext = area_ext[req_area];
    assign take = i_req & (st_q == ESB_ST_IDLE) & ~done_q & ~reject_q;

    // long wait areas and their count field
    assign req_longw = (req_area == 3'h0) | (req_area == 3'h2) | (req_area == 3'h6);
    assign req_lw = (req_area == 3'h6) ? i_long_wait_count_area_6 : i_long_wait_count_areas_0_2;

    // wait register selection by bus master and direction
    assign wait_bits = (i_kind == ESB_KIND_DMA_SINGLE) ? i_wait_ctrl_reg_second : i_wait_ctrl_reg_first;
    // processor and dual writes ignore the first register and always wait
    assign req_use_wait = (i_write & (i_kind != ESB_KIND_DMA_SINGLE)) | wait_bits[req_area];
    // area 3 loses its wait pin to the area 7 select
    assign req_pin_ok = req_use_wait & (req_area != `ESB_AREA_NOPIN);

    // bus width per area
    always_comb begin
        req_wide = 1'b0;
        case (req_area)
            3'h0: req_wide = (i_boot_mode_pins == `ESB_BOOT_EXT16);
            3'h1: req_wide = req_top;
            3'h2: req_wide = req_top;
            3'h3: req_wide = req_top;
            3'h4: req_wide = req_top;
            3'h5: req_wide = 1'b1;
            3'h6: req_wide = req_top | i_addr[`ESB_MUXIO_WIDTH_BIT];
            3'h7: req_wide = 1'b0;
            default: req_wide = 1'b0;
        endcase
    end

    // state timer
    assign running = (st_q != ESB_ST_IDLE);
    esb_state_timer #(
        .TPS(TPS),
        .TW(TW)
    ) u_timer (
        .i_clk(I_CLK_SYS),
        .i_rst_n(I_RST_N),
        .i_run(running),
        .o_tick(tick),
        .o_last(st_last)
    );

    // bus state sequencer, leaves idle on a taken request to an external area, else moves only at the last tick of a state
    always_comb begin
        st_d = st_q;
        left_d = left_q;
        finish = 1'b0;
        case (st_q)
            ESB_ST_IDLE: begin
                if (take & req_ext) begin
                    st_d = ESB_ST_FIRST;
                end
            end
            ESB_ST_FIRST: begin
                if (st_last) begin
                    if (!longw_q) begin
                        if (!use_wait_q) begin
                            finish = 1'b1;
                            st_d = ESB_ST_IDLE;
                        end else if (pin_ok_q && !I_WAIT_N) begin
                            st_d = ESB_ST_PINWAIT;
                        end else begin
                            st_d = ESB_ST_FINAL;
                        end
                    end else if (lw_q == 2'h0 && pin_ok_q && !I_WAIT_N) begin
                        // single long wait: its sample point is the end of the first state
                        st_d = ESB_ST_PINWAIT;
                    end else begin
                        st_d = ESB_ST_LONG;
                        left_d = lw_q;
                    end
                end
            end
            ESB_ST_LONG: begin
                if (st_last) begin
                    if (left_q == 2'h0) begin
                        finish = 1'b1;
                        st_d = ESB_ST_IDLE;
                    end else if (left_q == 2'h1 && pin_ok_q && !I_WAIT_N) begin
                        st_d = ESB_ST_PINWAIT;
                    end else begin
                        left_d = left_q - 2'h1;
                    end
                end
            end
            ESB_ST_PINWAIT: begin
                // hold while the pin is low, then the last state
                if (st_last && I_WAIT_N) begin
                    if (longw_q) begin
                        st_d = ESB_ST_LONG;
                        left_d = 2'h0;
                    end else begin
                        st_d = ESB_ST_FINAL;
                    end
                end
            end
            ESB_ST_FINAL: begin
                if (st_last) begin
                    finish = 1'b1;
                    st_d = ESB_ST_IDLE;
                end
            end
            default: begin
                st_d = ESB_ST_IDLE;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            st_q <= ESB_ST_IDLE;
            left_q <= 2'h0;
        end else begin
            st_q <= st_d;
            left_q <= left_d;
        end
    end

    // capture the access so pins stay steady through all states
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            addr_q <= '0;
            area_q <= '0;
            write_q <= 1'b0;
            word_q <= 1'b0;
            wide_q <= 1'b0;
            longw_q <= 1'b0;
            use_wait_q <= 1'b0;
            pin_ok_q <= 1'b0;
            lw_q <= 2'h0;
            duty_q <= 1'b0;
            style_q <= 1'b0;
            wdata_q <= '0;
        end else if (take && req_ext) begin
            addr_q <= i_addr;
            area_q <= req_area;
            write_q <= i_write;
            word_q <= i_word;
            wide_q <= req_wide;
            longw_q <= req_longw;
            use_wait_q <= req_use_wait;
            pin_ok_q <= req_pin_ok;
            lw_q <= req_lw;
            duty_q <= i_read_strobe_duty_select;
            style_q <= i_byte_strobe_style;
            wdata_q <= i_wdata;
        end
    end

    // answer pulses and read data
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            done_q <= 1'b0;
            reject_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            done_q <= finish;
            reject_q <= take & ~req_ext;
            if (finish && !write_q) begin
                rdata_q <= i_data_in;
            end
        end
    end

    // strobe timing inside the cycle
    logic in_first;
    logic [TW-1:0] rd_hi;
    logic rd_act;
    logic st_act;
    logic upper;
    logic lower;
    logic byte_sel_up;
    logic byte_sel_lo;

    assign in_first = (st_q == ESB_ST_FIRST);
    // high share of the first state before the read strobe falls
    assign rd_hi = duty_q ? TW'(HI_SHORT) : TW'(HI_HALF);
    assign rd_act = running & ~write_q & ~(in_first & (tick < rd_hi));
    // store strobe falls at the middle of the first state
    assign st_act = running & write_q & ~(in_first & (tick < TW'(HI_HALF)));

    // byte lanes: even address is the upper byte
    assign upper = word_q | ~addr_q[0];
    assign lower = word_q | addr_q[0];
    assign byte_sel_up = running & wide_q & upper;
    assign byte_sel_lo = running & wide_q & lower;

    // shared pin functions picked by the strobe style
    always_comb begin
        o_pin_a0_upsel_n = addr_q[0];
        o_pin_upst_losel_n = 1'b1;
        o_pin_lost_st_n = ~st_act;
        if (!wide_q) begin
            // narrow space: address bit, common store, middle pin idle
            o_pin_a0_upsel_n = addr_q[0];
            o_pin_upst_losel_n = 1'b1;
            o_pin_lost_st_n = ~st_act;
        end else if (style_q) begin
            o_pin_a0_upsel_n = ~byte_sel_up;
            o_pin_upst_losel_n = ~byte_sel_lo;
            o_pin_lost_st_n = ~st_act;
        end else begin
            o_pin_a0_upsel_n = addr_q[0];
            o_pin_upst_losel_n = ~(st_act & upper);
            o_pin_lost_st_n = ~(st_act & lower);
        end
    end

    // address, chip selects and data bus
    always_comb begin
        o_cs_n = `ESB_CS_IDLE;
        if (running) begin
            o_cs_n[area_q] = 1'b0;
        end
    end
    assign o_addr = addr_q[21:0];
    assign o_rd_n = ~rd_act;
    assign o_data_out = wdata_q;
    assign o_data_oe = running & write_q;

    // dram store pitch follows the pitch bit only with dram space on
    assign o_store_pitch_long = i_dram_space_enable & i_wait_ctrl_reg_first[`ESB_WCR_PITCH_BIT];

    // status
    assign o_busy = running | done_q | reject_q;
    assign o_done = done_q;
    assign o_reject = reject_q;
    assign o_rdata = rdata_q;
endmodule : esb_sram_cycle

// >>> esb_sram_cycle_monitor.sv
// port checker of the external sram bus cycle generator
`timescale 1ns/100ps
module esb_sram_cycle_chk #(
    parameter int TPS = 20
) (
    // clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    // request and configuration
    input wire logic i_req,
    input wire logic i_dram_space_enable,
    input wire logic [7:0] i_wait_ctrl_reg_first,
    // answer and pins
    input wire logic o_busy,
    input wire logic o_done,
    input wire logic o_reject,
    input wire logic [21:0] o_addr,
    input wire logic [7:0] o_cs_n,
    input wire logic o_rd_n,
    input wire logic o_data_oe,
    input wire logic o_store_pitch_long
);
    default clocking dcb @(posedge I_CLK_SYS);
    endclocking
    default disable iff (!I_RST_N);
    // count of selected cycles in the running access
    wire act = o_cs_n != 8'hFF;
    logic [15:0] act_q;
    wire [15:0] act_d = (act && I_RST_N) ? act_q + 16'h1 : 16'h0;
    always_ff @(posedge I_CLK_SYS) begin
        act_q <= act_d;
    end
    // relations between the ports
    reject_quiet_a: assert property (o_reject |-> !act && !o_done)
        else $error("reject with select active");
    reject_take_a: assert property (o_reject |-> $past(i_req && !o_busy))
        else $error("reject without a taken request");
    done_pulse_a: assert property (o_done |=> !o_done)
        else $error("done longer than one cycle");
    whole_states_a: assert property (o_done |-> act_q != 16'h0 && act_q % TPS == 0)
        else $error("access not a whole number of states");
    one_select_a: assert property ($onehot0(~o_cs_n))
        else $error("more than one chip select low");
    addr_steady_a: assert property (act && $past(act) |-> $stable(o_addr) && $stable(o_cs_n))
        else $error("address or select moved inside access");
    read_first_high_a: assert property ($rose(act) && !o_data_oe |-> o_rd_n)
        else $error("read strobe low at first tick");
    idle_pins_a: assert property (!o_busy |-> !act && o_rd_n && !o_data_oe)
        else $error("pins active while idle");
    pitch_pick_a: assert property (o_store_pitch_long == (i_dram_space_enable && i_wait_ctrl_reg_first[1]))
        else $error("store pitch not from pitch bit");
    // main scenarios
    cover property (o_reject);
    cover property (o_done && $past(o_data_oe));
    cover property (o_done && act_q >= 16'(3 * TPS));
endmodule : esb_sram_cycle_chk
bind esb_sram_cycle esb_sram_cycle_chk #(.TPS(TPS)) u_chk (.*);

// >>> esb_sram_model.sv
// behavioural sram with wait pin, far side of the bus cycle generator
`timescale 1ns/100ps
module esb_sram_model (
    // pins from the generator
    input wire logic i_clk,
    input wire logic [7:0] i_cs_n,
    input wire logic i_rd_n,
    input wire logic [21:0] i_addr,
    // bench control: wait held low through this many selected cycles
    input wire logic [15:0] i_low_till,
    // pins to the generator
    output logic o_wait_n,
    output logic [15:0] o_data
);
    logic [15:0] cnt_q;
    logic [15:0] last_q = 16'h0;
    wire act = i_cs_n != 8'hFF;
    wire [15:0] cnt_d = act ? cnt_q + 16'h1 : 16'h0;
    // selected cycle counter and last driven word
    always_ff @(posedge i_clk) begin
        cnt_q <= cnt_d;
        last_q <= o_data;
    end
    // wait low for the chosen span, pulled up outside accesses
    assign o_wait_n = !(act && cnt_q < i_low_till);
    // middle pin is never looked at, so narrow spaces may leave it idle
    assign o_data = (act && !i_rd_n) ? {i_addr[7:0], ~i_addr[7:0]} : ~last_q;
endmodule : esb_sram_model

// >>> esb_sram_cycle_tb_top.sv
// self-checking bench of the external sram bus cycle generator
`timescale 1ns/100ps
module esb_sram_cycle_tb_top import esb_pkg::*;;
    localparam int TPS = 20;
    logic I_CLK_SYS = 1'b0;
    logic I_RST_N = 1'b0;
    logic [2:0] boot = 3'h0;
    logic dram = 1'b0, mioe = 1'b0, duty = 1'b0, style = 1'b0, req = 1'b0, wr = 1'b0, word = 1'b0;
    logic [7:0] wait_ctrl_reg_first = 8'hFF, wait_ctrl_reg_second = 8'hFF;
    logic [1:0] l02 = 2'h0, l6 = 2'h0, kind = 2'h0;
    logic [27:0] addr = 28'h0;
    logic [15:0] wdata = 16'h0, low_till = 16'h0, rdata, din, dout;
    logic busy, done, rej, wait_n, oe, rd_n, p0, p1, p2;
    logic [21:0] a_o;
    logic [7:0] cs_n;
    int n_errors = 0, samples_checked = 0;
    // clock at 10 MHz, fast enough for the short read duty
    always #50 I_CLK_SYS = ~I_CLK_SYS;
    // design and far side
    esb_sram_cycle #(.TPS(TPS)) uut (.I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .i_boot_mode_pins(boot),
        .i_dram_space_enable(dram), .i_mux_io_space_enable(mioe), .i_read_strobe_duty_select(duty),
        .i_byte_strobe_style(style), .i_wait_ctrl_reg_first(wait_ctrl_reg_first), .i_wait_ctrl_reg_second(wait_ctrl_reg_second),
        .i_long_wait_count_areas_0_2(l02), .i_long_wait_count_area_6(l6), .i_req(req), .i_addr(addr),
        .i_write(wr), .i_word(word), .i_kind(esb_kind_t'(kind)), .i_wdata(wdata), .o_busy(busy), .o_done(done),
        .o_reject(rej), .o_rdata(rdata), .I_WAIT_N(wait_n), .i_data_in(din), .o_data_out(dout), .o_data_oe(oe),
        .o_addr(a_o), .o_cs_n(cs_n), .o_rd_n(rd_n), .o_pin_a0_upsel_n(p0), .o_pin_upst_losel_n(p1),
        .o_pin_lost_st_n(p2), .o_store_pitch_long());
    esb_sram_model u_mem (.i_clk(I_CLK_SYS), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_addr(a_o),
        .i_low_till(low_till), .o_wait_n(wait_n), .o_data(din));
    // compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // verdict and end of run
    task automatic results();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    // areas that are plain external memory
    function automatic bit is_sram(input logic [2:0] ar, input logic top);
        case (ar)
            3'h0: return boot <= 3'h1;
            3'h1: return !dram;
            3'h5: return top;
            3'h6: return !mioe || top;
            3'h7: return !top;
            default: return 1'b1;
        endcase
    endfunction : is_sram
    // eight bit spaces
    function automatic bit narrow(input logic [27:0] a);
        if (a[26:24] == 3'h7)
            return 1'b1;
        if (a[26:24] == 3'h0)
            return boot == 3'h0;
        if (a[26:24] == 3'h5)
            return 1'b0;
        return !a[27] && (a[26:24] != 3'h6 || !a[14]);
    endfunction : narrow
    // states of one access with k pin waits offered
    function automatic int states(input logic [2:0] ar, input int k);
        logic w;
        int l;
        w = (kind == 2'h2) ? wait_ctrl_reg_second[ar] : (wr || wait_ctrl_reg_first[ar]);
        l = (ar == 3'h6) ? l6 + 1 : l02 + 1;
        if (ar inside {3'h0, 3'h2, 3'h6})
            return 1 + l + (w ? k : 0);
        if (!w)
            return 1;
        return (ar == 3'h3) ? 2 : 2 + k;
    endfunction : states
    // one access from take to answer
    task automatic run(input int k);
        int n, s, t;
        logic [2:0] ar;
        logic up, lo;
        ar = addr[26:24];
        s = (ar inside {3'h0, 3'h2, 3'h6}) ? ((ar == 3'h6) ? l6 : l02) + 1 : 1;
        low_till = (k > 0) ? 16'((s + k - 1) * TPS) : 16'h0;
        n = states(ar, k);
        up = word || !addr[0];
        lo = word || addr[0];
        req = 1'b1;
        @(negedge I_CLK_SYS);
        req = 1'b0;
        if (!is_sram(ar, addr[27])) begin
            chk({15'h0, rej}, 16'h1);
            return;
        end
        for (t = 1; !done && t < 400; t++) begin
            if (!wr && (t == 1 || t == 8))
                chk({15'h0, rd_n}, {15'h0, t == 1 || !duty});
            if (t == TPS) begin
                chk({8'h0, cs_n}, {8'h0, ~(8'h1 << ar)});
                chk(a_o[15:0], addr[15:0]);
                chk({10'h0, a_o[21:16]}, {10'h0, addr[21:16]});
                if (wr)
                    chk(dout, wdata);
                if (narrow(addr))
                    chk({11'h0, p0, p1, p2, rd_n, oe}, {11'h0, addr[0], 1'b1, !wr, wr, wr});
                else if (style)
                    chk({11'h0, p0, p1, p2, rd_n, oe}, {11'h0, !up, !lo, !wr, wr, wr});
                else
                    chk({11'h0, p0, p1, p2, rd_n, oe}, {11'h0, addr[0], !(wr && up), !(wr && lo), wr, wr});
            end
            @(negedge I_CLK_SYS);
        end
        chk(16'(t), 16'(n * TPS + 1));
        if (!wr)
            chk(rdata, {addr[7:0], ~addr[7:0]});
        @(negedge I_CLK_SYS);
    endtask : run
    // reset, then corner areas and random accesses
    initial begin
        void'($urandom(32'h9A110DD7));
        repeat (8) @(posedge I_CLK_SYS);
        @(negedge I_CLK_SYS);
        chk({cs_n, 5'h0, rd_n, busy, oe}, {8'hFF, 5'h0, 1'b1, 1'b0, 1'b0});
        I_RST_N = 1'b1;
        for (int i = 0; i < 64; i++) begin
            while (busy)
                @(negedge I_CLK_SYS);
            {dram, mioe, duty, style} = 4'($urandom);
            boot = 3'($urandom % 3);
            wait_ctrl_reg_first = {6'h3F, !dram || 1'($urandom), 1'b1};
            wait_ctrl_reg_second = 8'($urandom);
            {l02, l6, wr, word, kind} = 8'($urandom);
            addr = 28'($urandom);
            if (i < 16)
                addr[26:24] = 3'(i);
            if (narrow(addr))
                word = 1'b0;
            if (word)
                addr[0] = 1'b0;
            wdata = 16'($urandom);
            run(i % 3);
        end
        results();
    end
    // watchdog
    initial begin
        #2000000;
        n_errors++;
        results();
    end
endmodule : esb_sram_cycle_tb_top
